// *** hdl/exec_unit_pkg.sv ***
// constants, types and shared functions of the add and bit-operation execution unit
// assumes one core clock; instruction words come in through the register bus
// Summary of operation
// - add literal to accumulator: acc plus 8-bit immediate into acc, flags C, half-carry, Z
// - add accumulator and register byte at 7-bit address, flags C, half-carry, Z
// - destination bit 0 sends result to acc, 1 writes it back to the register
// - AND literal with accumulator into acc, only zero flag changes
// - AND accumulator with register byte to chosen destination, only zero flag changes
// - bit clear forces chosen bit 0 to 7 of register to zero, flags untouched
// - bit set forces chosen bit 0 to 7 of register to one, flags untouched
// - skip-if-one discards next instruction as no-op when tested bit is one
// - skip-if-zero discards next instruction as no-op when tested bit is zero
// - bit ops: prefix 01, sub-op clear/set/skip-zero/skip-one, bit number, address
// - byte ops: prefix 00, opcode 0111 add or 0101 AND, destination, address
// - literal ops: prefix 11, add is 111x, AND is 1001, immediate low byte
`default_nettype none
package exec_unit_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int INSTR_W = 14;
    localparam int RF_ADDR_W = 7;
    localparam int RF_DEPTH = 128;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] INSTR_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] ACC_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] WIN_ADDR_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] WIN_DATA_OFS = 8'h10;

    // status register bit positions
    localparam int CARRY_BIT = 0;
    localparam int HALF_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int SKIP_BIT = 3;
    localparam int BUSY_BIT = 4;
    localparam int UNSUP_BIT = 5;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;
    localparam logic [RF_ADDR_W-1:0] WIN_RST = 7'h00;

    // instruction cycle: four core clocks, last phase ends the cycle
    localparam logic [1:0] TCY_LAST = 2'h3;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // instruction field positions
    localparam int PFX_HI = 13;
    localparam int PFX_LO = 12;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 8;
    localparam int DEST_POS = 7;
    localparam int SUB_HI = 11;
    localparam int SUB_LO = 10;
    localparam int BITN_HI = 9;
    localparam int BITN_LO = 7;
    localparam int LIT_HI = 7;
    localparam int FADR_HI = 6;

    // encodings
    localparam logic [1:0] PFX_BYTE = 2'h0;
    localparam logic [1:0] PFX_BIT = 2'h1;
    localparam logic [1:0] PFX_LIT = 2'h3;
    localparam logic [3:0] OPC_ADD = 4'h7;
    localparam logic [3:0] OPC_AND = 4'h5;
    localparam logic [2:0] LIT_ADD_TOP = 3'h7;
    localparam logic [3:0] LIT_AND = 4'h9;
    localparam logic [1:0] SUB_CLEAR = 2'h0;
    localparam logic [1:0] SUB_SET = 2'h1;
    localparam logic [1:0] SUB_SKIP_ZERO = 2'h2;
    localparam logic [1:0] SUB_SKIP_ONE = 2'h3;

    typedef enum logic [3:0] {
        op_none, add_literal_to_acc, and_literal_with_acc, add_acc_and_reg,
        and_acc_with_reg, bit_clear_op, bit_set_op, skip_if_bit_zero, skip_if_bit_one
    } op_type;

    typedef enum logic [1:0] {st_idle, st_fetch, st_exec} exec_state_type;

    // instruction word to operation; anything else of the set is op_none
    function automatic op_type decode_op(input logic [INSTR_W-1:0] w);
        op_type op;
        op = op_none;
        if (w[PFX_HI:PFX_LO] == PFX_BIT) begin
            case (w[SUB_HI:SUB_LO])
                SUB_CLEAR: op = bit_clear_op;
                SUB_SET: op = bit_set_op;
                SUB_SKIP_ZERO: op = skip_if_bit_zero;
                default: op = skip_if_bit_one;
            endcase
        end else if (w[PFX_HI:PFX_LO] == PFX_BYTE) begin
            if (w[OPC_HI:OPC_LO] == OPC_ADD) begin
                op = add_acc_and_reg;
            end else if (w[OPC_HI:OPC_LO] == OPC_AND) begin
                op = and_acc_with_reg;
            end
        end else if (w[PFX_HI:PFX_LO] == PFX_LIT) begin
            if (w[OPC_HI:OPC_LO+1] == LIT_ADD_TOP) begin // low opcode bit ignored
                op = add_literal_to_acc;
            end else if (w[OPC_HI:OPC_LO] == LIT_AND) begin
                op = and_literal_with_acc;
            end
        end
        return op;
    endfunction

    // merge a bus write into a register word by byte strobes
    function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] nw,
                                                    input logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// *** hdl/rf_if.sv ***
// port bundle between the execution core and its register-file memory
// assumes a single read/write port with one cycle of read latency
`timescale 1ns/100ps
`default_nettype none
interface rf_if;
    logic [6:0] addr;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// *** hdl/regfile_mem.sv ***
// 128-byte register file with registered read data
// assumes the controller holds the address one cycle ahead of the data it needs
`timescale 1ns/100ps
`default_nettype none
module regfile_mem import exec_unit_pkg::*; (
    input wire logic ref_clk, // core clock
    rf_if.mem port            // address, write and read data
);
    logic [7:0] mem [RF_DEPTH];
    logic [7:0] rdata_reg;

    // read-before-write: a same-cycle write shows up on the next read
    always_ff @(posedge ref_clk) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        rdata_reg <= mem[port.addr];
    end

    assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

// *** hdl/add_and_bit_op_exec_unit.sv ***
// add, AND and bit-operation execution unit with an AXI4-Lite register slave
// assumes software feeds instruction words one at a time through the instruction register
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module add_and_bit_op_exec_unit import exec_unit_pkg::*; (
    input wire logic ref_clk,               // core clock, 25 MHz
    input wire logic reset,                 // synchronous, active high
    input wire logic [ADDR_W-1:0] awaddr,   // write address
    input wire logic awvalid,               // write address valid
    output logic awready,                   // write address ready
    input wire logic [DATA_W-1:0] wdata,    // write data
    input wire logic [3:0] wstrb,           // write byte strobes
    input wire logic wvalid,                // write data valid
    output logic wready,                    // write data ready
    output logic [1:0] bresp,               // write response
    output logic bvalid,                    // write response valid
    input wire logic bready,                // write response ready
    input wire logic [ADDR_W-1:0] araddr,   // read address
    input wire logic arvalid,               // read address valid
    output logic arready,                   // read address ready
    output logic [DATA_W-1:0] rdata,        // read data
    output logic [1:0] rresp,               // read response
    output logic rvalid,                    // read data valid
    input wire logic rready                 // read data ready
);
    rf_if rf ();
    regfile_mem u_mem (.ref_clk(ref_clk), .port(rf.mem));

    logic [1:0] phase_reg, phase_next;
    logic tcy_en;
    exec_state_type state_reg, state_next;
    logic [INSTR_W-1:0] instr_reg, instr_next;
    logic pending_reg, pending_next;
    logic [7:0] acc_reg, acc_next;
    logic carry_reg, carry_next, half_reg, half_next, zero_reg, zero_next;
    logic skip_reg, skip_next, unsup_reg, unsup_next;
    logic [RF_ADDR_W-1:0] win_reg, win_next;
    logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next, araddr_reg, araddr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic rd_wait_reg, rd_wait_next, rd_issue_reg, rd_issue_next;
    logic bus_ok, wr_do, rd_go, exec_we, bus_we;
    logic [7:0] alu_b, exec_wdata, bit_mask;
    logic [8:0] sum_w;
    logic [4:0] half_sum;
    logic [DATA_W-1:0] status_word, merged;
    op_type op;

    // instruction-cycle divider: one enable pulse every four clocks
    always_comb begin
        phase_next = phase_reg + 2'h1;
        tcy_en = (phase_reg == TCY_LAST);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // operand and flag arithmetic shared by the adds and ANDs
    always_comb begin
        op = decode_op(instr_reg);
        alu_b = (op == add_literal_to_acc || op == and_literal_with_acc) ? instr_reg[LIT_HI:0] : rf.rdata;
        sum_w = {1'b0, acc_reg} + {1'b0, alu_b};            // bit 8 is carry out of bit 7
        half_sum = {1'b0, acc_reg[3:0]} + {1'b0, alu_b[3:0]}; // bit 4 is carry out of bit 3
        bit_mask = 8'h01 << instr_reg[BITN_HI:BITN_LO];
        status_word = '0;
        status_word[CARRY_BIT] = carry_reg;
        status_word[HALF_BIT] = half_reg;
        status_word[ZERO_BIT] = zero_reg;
        status_word[SKIP_BIT] = skip_reg;
        status_word[BUSY_BIT] = pending_reg || (state_reg != st_idle);
        status_word[UNSUP_BIT] = unsup_reg;
    end

    // bus actions wait until the core is idle so they never race an instruction
    assign bus_ok = (state_reg == st_idle) && !pending_reg;
    assign wr_do = aw_got_reg && w_got_reg && !bvalid_reg && bus_ok;
    assign rd_go = rd_wait_reg && bus_ok;
    assign awready = !aw_got_reg && !bvalid_reg;
    assign wready = !w_got_reg && !bvalid_reg;
    assign arready = !rd_wait_reg && !rd_issue_reg && !rvalid_reg;
    assign bus_we = wr_do && (awaddr_reg == WIN_DATA_OFS) && wstrb_reg[0];
    assign rf.addr = (state_reg == st_idle) ? win_reg : instr_reg[FADR_HI:0];
    assign rf.we = exec_we || bus_we;
    assign rf.wdata = exec_we ? exec_wdata : wdata_reg[7:0];

    // execution sequencer and register slave
    always_comb begin
        state_next = state_reg;
        instr_next = instr_reg;
        pending_next = pending_reg;
        acc_next = acc_reg;
        carry_next = carry_reg;
        half_next = half_reg;
        zero_next = zero_reg;
        skip_next = skip_reg;
        unsup_next = unsup_reg;
        win_next = win_reg;
        exec_we = 1'b0;
        exec_wdata = sum_w[7:0];
        merged = '0;
        case (state_reg)
            st_idle: begin
                if (tcy_en && pending_reg) begin // one instruction starts per cycle pulse
                    state_next = st_fetch;
                    pending_next = 1'b0;
                end
            end
            st_fetch: state_next = st_exec;
            default: begin
                state_next = st_idle;
                if (skip_reg) begin
                    skip_next = 1'b0; // discarded word runs as a no-op cycle
                end else begin
                    unsup_next = (op == op_none);
                    case (op)
                        add_literal_to_acc, add_acc_and_reg: begin
                            carry_next = sum_w[8];
                            half_next = half_sum[4];
                            zero_next = (sum_w[7:0] == 8'h00);
                            exec_wdata = sum_w[7:0];
                            if (op == add_acc_and_reg && instr_reg[DEST_POS]) begin
                                exec_we = 1'b1;
                            end else begin
                                acc_next = sum_w[7:0];
                            end
                        end
                        and_literal_with_acc, and_acc_with_reg: begin
                            zero_next = ((acc_reg & alu_b) == 8'h00);
                            exec_wdata = acc_reg & alu_b;
                            if (op == and_acc_with_reg && instr_reg[DEST_POS]) begin
                                exec_we = 1'b1;
                            end else begin
                                acc_next = acc_reg & alu_b;
                            end
                        end
                        bit_clear_op: begin
                            exec_we = 1'b1;
                            exec_wdata = rf.rdata & ~bit_mask;
                        end
                        bit_set_op: begin
                            exec_we = 1'b1;
                            exec_wdata = rf.rdata | bit_mask;
                        end
                        skip_if_bit_zero: skip_next = !rf.rdata[instr_reg[BITN_HI:BITN_LO]];
                        skip_if_bit_one: skip_next = rf.rdata[instr_reg[BITN_HI:BITN_LO]];
                        default: ;
                    endcase
                end
            end
        endcase

        // write channel: address and data taken in either order
        aw_got_next = aw_got_reg || (awvalid && awready);
        w_got_next = w_got_reg || (wvalid && wready);
        awaddr_next = (awvalid && awready) ? awaddr : awaddr_reg;
        wdata_next = (wvalid && wready) ? wdata : wdata_reg;
        wstrb_next = (wvalid && wready) ? wstrb : wstrb_reg;
        bvalid_next = bvalid_reg && !bready;
        bresp_next = bresp_reg;
        if (wr_do) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            if (awaddr_reg == INSTR_OFS) begin
                merged = apply_strb({18'h00000, instr_reg}, wdata_reg, wstrb_reg);
                instr_next = merged[INSTR_W-1:0];
                pending_next = 1'b1;
            end else if (awaddr_reg == ACC_OFS) begin
                merged = apply_strb({24'h000000, acc_reg}, wdata_reg, wstrb_reg);
                acc_next = merged[7:0];
            end else if (awaddr_reg == STATUS_OFS) begin
                merged = apply_strb(status_word, wdata_reg, wstrb_reg);
                carry_next = merged[CARRY_BIT];
                half_next = merged[HALF_BIT];
                zero_next = merged[ZERO_BIT];
                skip_next = merged[SKIP_BIT];
            end else if (awaddr_reg == WIN_ADDR_OFS) begin
                merged = apply_strb({25'h0000000, win_reg}, wdata_reg, wstrb_reg);
                win_next = merged[RF_ADDR_W-1:0];
            end else if (awaddr_reg != WIN_DATA_OFS) begin
                bresp_next = RESP_SLVERR;
            end
        end

        // read channel: wait, one cycle for the memory, then answer
        rd_wait_next = (rd_wait_reg && !rd_go) || (arvalid && arready);
        araddr_next = (arvalid && arready) ? araddr : araddr_reg;
        rd_issue_next = rd_go;
        rvalid_next = rvalid_reg && !rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rd_issue_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            if (araddr_reg == INSTR_OFS) begin
                rdata_next = {18'h00000, instr_reg};
            end else if (araddr_reg == ACC_OFS) begin
                rdata_next = {24'h000000, acc_reg};
            end else if (araddr_reg == STATUS_OFS) begin
                rdata_next = status_word;
            end else if (araddr_reg == WIN_ADDR_OFS) begin
                rdata_next = {25'h0000000, win_reg};
            end else if (araddr_reg == WIN_DATA_OFS) begin
                rdata_next = {24'h000000, rf.rdata};
            end else begin
                rdata_next = '0;
                rresp_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= st_idle;
            instr_reg <= INSTR_RST;
            pending_reg <= 1'b0;
            acc_reg <= ACC_RST;
            carry_reg <= 1'b0;
            half_reg <= 1'b0;
            zero_reg <= 1'b0;
            skip_reg <= 1'b0;
            unsup_reg <= 1'b0;
            win_reg <= WIN_RST;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rd_wait_reg <= 1'b0;
            rd_issue_reg <= 1'b0;
            araddr_reg <= '0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            state_reg <= state_next;
            instr_reg <= instr_next;
            pending_reg <= pending_next;
            acc_reg <= acc_next;
            carry_reg <= carry_next;
            half_reg <= half_next;
            zero_reg <= zero_next;
            skip_reg <= skip_next;
            unsup_reg <= unsup_next;
            win_reg <= win_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rd_wait_reg <= rd_wait_next;
            rd_issue_reg <= rd_issue_next;
            araddr_reg <= araddr_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
endmodule
`default_nettype wire

// *** verification/exec_unit_monitor.sv ***
// bus handshake checker for the execution unit
// assumes it is bound to the unit top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module exec_unit_monitor import exec_unit_pkg::*; (
    input wire logic ref_clk, // clock
    input wire logic reset, // sync reset
    input wire logic [ADDR_W-1:0] awaddr, // aw addr
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic [1:0] bresp, // b resp
    input wire logic bvalid, // b valid
    input wire logic bready, // b ready
    input wire logic [ADDR_W-1:0] araddr, // ar addr
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [DATA_W-1:0] rdata, // r data
    input wire logic [1:0] rresp, // r resp
    input wire logic rvalid, // r valid
    input wire logic rready // r ready
);
    logic aw_bad_reg, aw_bad_next, ar_bad_reg, ar_bad_next;
    // remember whether each taken address misses the map
    always_comb begin
        aw_bad_next = aw_bad_reg;
        ar_bad_next = ar_bad_reg;
        if (awvalid && awready) aw_bad_next = awaddr > WIN_DATA_OFS || awaddr[1:0] != 2'h0;
        if (arvalid && arready) ar_bad_next = araddr > WIN_DATA_OFS || araddr[1:0] != 2'h0;
        if (reset) begin
            aw_bad_next = 1'b0;
            ar_bad_next = 1'b0;
        end
    end
    // register the flags
    always_ff @(posedge ref_clk) begin
        aw_bad_reg <= aw_bad_next;
        ar_bad_reg <= ar_bad_next;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_reset_idle: assert property ($fell(reset) |-> awready && wready && arready && !bvalid && !rvalid)
        else $error("bus not idle after reset");
    a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
    a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped");
    a_write_blocked: assert property (bvalid |-> !awready && !wready) else $error("write taken during answer");
    a_read_blocked: assert property (rvalid |-> !arready) else $error("read taken during answer");
    a_bresp_code: assert property (bvalid |-> bresp == (aw_bad_reg ? RESP_SLVERR : RESP_OKAY))
        else $error("wrong write response");
    a_rresp_code: assert property (rvalid |-> rresp == (ar_bad_reg ? RESP_SLVERR : RESP_OKAY)
        && (!ar_bad_reg || rdata == '0)) else $error("wrong read response");
    a_write_answer: assert property (awvalid && awready |-> ##[1:12] bvalid)
        else $error("write answer late");
    a_read_answer: assert property (arvalid && arready |-> ##[1:12] rvalid)
        else $error("read answer late");
    a_read_pad: assert property (rvalid |-> rdata[31:14] == '0) else $error("unused read bits set");
    c_bad_write: cover property (bvalid && bresp == RESP_SLVERR);
    c_bad_read: cover property (rvalid && rresp == RESP_SLVERR);
    c_instr: cover property (awvalid && awready && awaddr == INSTR_OFS);
endmodule
bind add_and_bit_op_exec_unit exec_unit_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench of the execution unit over its register bus
// assumes the unit top alone; answers are always accepted at once
`timescale 1ns/100ps
`default_nettype none
module tb_top import exec_unit_pkg::*;;
    logic ref_clk, reset, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int err_count, comparisons, cyc;
    add_and_bit_op_exec_unit u_dut (.ref_clk(ref_clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // cut a hang short; the whole run needs under a thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write; address and data offered together, each dropped when taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    // one read; rready is held high for the whole run
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    // issue one instruction and wait until the core is idle again
    task automatic ex(input logic [INSTR_W-1:0] i);
        logic [DATA_W-1:0] s;
        logic [1:0] r;
        wr(INSTR_OFS, {18'h0, i}, RESP_OKAY);
        do rd(STATUS_OFS, s, r); while (s[BUSY_BIT] !== 1'b0);
    endtask
    initial begin
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        logic [1:0] sub;
        logic skip;
        reset = 1'b1;
        {awvalid, wvalid, arvalid} = 3'h0;
        {bready, rready} = 2'h3;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rc(ACC_OFS, 32'h0);
        rc(STATUS_OFS, 32'h0);
        rc(WIN_ADDR_OFS, 32'h0);
        $display("test reset done");
        // literal add and AND, flags from the low nibble and bit 7
        wr(ACC_OFS, 32'h0F, RESP_OKAY);
        ex(14'h3E01);
        rc(ACC_OFS, 32'h10);
        rc(STATUS_OFS, 32'h02);
        ex(14'h3FF0);
        rc(ACC_OFS, 32'h00);
        rc(STATUS_OFS, 32'h05);
        wr(ACC_OFS, 32'h01, RESP_OKAY);
        ex(14'h3EFF);
        rc(STATUS_OFS, 32'h07);
        wr(ACC_OFS, 32'h3C, RESP_OKAY);
        wr(STATUS_OFS, 32'h03, RESP_OKAY);
        ex(14'h390F);
        rc(ACC_OFS, 32'h0C);
        rc(STATUS_OFS, 32'h03);
        ex(14'h3900);
        rc(STATUS_OFS, 32'h07);
        $display("test literal done");
        // register-file operands with both destinations
        wr(WIN_ADDR_OFS, 32'h7F, RESP_OKAY);
        wr(WIN_DATA_OFS, 32'h85, RESP_OKAY);
        wr(ACC_OFS, 32'h83, RESP_OKAY);
        wr(STATUS_OFS, 32'h0, RESP_OKAY);
        ex(14'h07FF);
        rc(WIN_DATA_OFS, 32'h08);
        rc(ACC_OFS, 32'h83);
        rc(STATUS_OFS, 32'h01);
        ex(14'h057F);
        rc(ACC_OFS, 32'h00);
        rc(STATUS_OFS, 32'h05);
        ex(14'h077F);
        rc(ACC_OFS, 32'h08);
        rc(WIN_DATA_OFS, 32'h08);
        $display("test byte done");
        // set then clear every bit; flags must not move
        wr(WIN_ADDR_OFS, 32'h0, RESP_OKAY);
        wr(WIN_DATA_OFS, 32'h0, RESP_OKAY);
        wr(STATUS_OFS, 32'h07, RESP_OKAY);
        for (int b = 0; b < 8; b++) begin
            ex({PFX_BIT, SUB_SET, 3'(b), 7'h00});
            rc(WIN_DATA_OFS, (32'h2 << b) - 32'h1);
        end
        for (int b = 0; b < 8; b++) begin
            ex({PFX_BIT, SUB_CLEAR, 3'(b), 7'h00});
            rc(WIN_DATA_OFS, (32'hFF << (b + 1)) & 32'hFF);
        end
        rc(STATUS_OFS, 32'h07);
        $display("test bit done");
        // both skips on a one bit and a zero bit, then a follower add
        wr(WIN_DATA_OFS, 32'h01, RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            sub = (k > 1) ? SUB_SKIP_ONE : SUB_SKIP_ZERO;
            skip = (k > 1) == (k % 2 == 0);
            wr(ACC_OFS, 32'h0, RESP_OKAY);
            wr(STATUS_OFS, 32'h0, RESP_OKAY);
            ex({PFX_BIT, sub, 3'(k % 2), 7'h00});
            rc(STATUS_OFS, {28'h0, skip, 3'h0});
            ex(14'h3E01);
            rc(ACC_OFS, {31'h0, !skip});
            rc(STATUS_OFS, 32'h0);
        end
        $display("test skip done");
        // unmapped places answer with an error, busy is read-only
        wr(8'h14, 32'hFF, RESP_SLVERR);
        rd(8'h40, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(STATUS_OFS, 32'h10, RESP_OKAY);
        rc(STATUS_OFS, 32'h0);
        ex(14'h2000);
        rc(STATUS_OFS, 32'h20);
        $display("test map done");
        end_sim();
    end
endmodule
`default_nettype wire
